// [rtl/two_wire_cfg.svh]
// Purpose: Offsets, field positions, reset values and timing counts of the two-wire unit.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes:   Definitions only.
`ifndef TWO_WIRE_CFG_SVH
`define TWO_WIRE_CFG_SVH

`define TW_OFF_BUF      8'h00
`define TW_OFF_CTL1     8'h04
`define TW_OFF_CTL3     8'h08
`define TW_OFF_FLAGS    8'h0C
`define TW_OFF_CMD      8'h10
`define TW_OFF_OWN      8'h14

`define TW_C1_WCOL      7
`define TW_C1_OVF       6
`define TW_C1_EN        5
`define TW_C1_REL       4
`define TW_C1_MST       3
`define TW_C3_NACK      0
`define TW_CMD_START    0
`define TW_CMD_RESTART  1
`define TW_CMD_STOP     2
`define TW_CMD_RECV     3

`define TW_OWN_RESET    7'h00
`define TW_CLK_NS       5
`define TW_QTR_NS       2500
`define TW_QTR_CYC      ((`TW_QTR_NS + `TW_CLK_NS - 1) / `TW_CLK_NS)
`define TW_QW           10

`endif

// [rtl/two_wire_pkg.sv]
// Purpose: Types shared by the two-wire unit.
// Assumes: Constants come from two_wire_cfg.svh.
// Notes:   State of the unit is one packed struct, apart from the hold and output-enable flops.
package two_wire_pkg;
   typedef enum logic [3:0] {
      M_IDLE, M_STA1, M_STA2, M_LOW, M_HIGH, M_HOLD, M_STO1, M_STO2, M_STO3, M_RS1, M_RS2
   } mst_t;
   typedef enum logic [2:0] {S_IDLE, S_ADDR, S_RX, S_TX, S_WAIT} slv_t;
   typedef struct packed {
      logic [2:0]  scl_sy;
      logic [2:0]  sda_sy;
      logic        scl_f;
      logic        sda_f;
      mst_t        mst;
      logic [9:0]  qcnt;
      logic [3:0]  mbit;
      logic [7:0]  msh;
      logic        mrx;
      logic        mscl;
      logic        msda;
      slv_t        slv;
      logic [3:0]  sbit;
      logic [7:0]  ssh;
      logic        ssda;
      logic        sscl;
      logic        srw;
      logic [7:0]  buf_q;
      logic        full;
      logic        wcol;
      logic        ovf;
      logic        en;
      logic        rel;
      logic        mst_en;
      logic        nack_next;
      logic [6:0]  own;
      logic        arb;
      logic        mis;
      logic        nack_rx;
      logic        sto;
      logic        sta;
      logic        busy;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } state_t;
endpackage

// [rtl/two_wire_bus_signalling.sv]
// Purpose: Two-wire bus unit with master and slave engines behind an APB slave.
// Assumes: Bus lines are open drain with pull-ups; pclk is 200 MHz.
// Notes:   APB outputs are taken straight from the state register; the line enables come from their own flops.
`timescale 1ns/10ps
`include "two_wire_cfg.svh"

module two_wire_bus_signalling
   import two_wire_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe
);

   localparam logic [9:0] QLAST = 10'(`TW_QTR_CYC - 1);
   localparam logic [9:0] QHALF = 10'(`TW_QTR_CYC / 2);

   state_t q;
   state_t d;
   logic   nscl;
   logic   nsda;
   logic   scl_rise;
   logic   scl_fall;
   logic   start_det;
   logic   stop_det;
   logic   tick;
   logic   acc;
   logic   hold_q;
   logic   oe_scl_q;
   logic   oe_sda_q;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   // A change counts once the second and third stages agree.
   assign nscl      = (q.scl_sy[1] == q.scl_sy[2]) ? q.scl_sy[2] : q.scl_f;
   assign nsda      = (q.sda_sy[1] == q.sda_sy[2]) ? q.sda_sy[2] : q.sda_f;
   assign scl_rise  = nscl & ~q.scl_f;
   assign scl_fall  = ~nscl & q.scl_f;
   assign start_det = q.scl_f & nscl & q.sda_f & ~nsda;
   assign stop_det  = q.scl_f & nscl & ~q.sda_f & nsda;
   assign tick      = q.qcnt == QLAST;
   assign acc       = psel & penable;

   always_comb begin
      d = q;
      d.pready  = 1'b1;
      d.pslverr = 1'b0;
      d.scl_sy  = {q.scl_sy[1:0], scl_i};
      d.sda_sy  = {q.sda_sy[1:0], sda_i};
      d.scl_f   = nscl;
      d.sda_f   = nsda;
      d.qcnt    = q.qcnt + 10'h001;

      // Register read data is prepared in the setup cycle.
      if (psel && !penable) begin
         d.prdata  = 32'h0000_0000;
         d.pslverr = 1'b0;
         if (hit(paddr, `TW_OFF_BUF)) begin
            d.prdata[7:0] = q.buf_q;
         end else if (hit(paddr, `TW_OFF_CTL1)) begin
            d.prdata[7:0] = {q.wcol, q.ovf, q.en, q.rel, q.mst_en, 3'h0};
         end else if (hit(paddr, `TW_OFF_CTL3)) begin
            d.prdata[7:0] = {7'h00, q.nack_next};
         end else if (hit(paddr, `TW_OFF_FLAGS)) begin
            d.prdata[7:0] = {q.arb, q.mis, q.nack_rx, q.sto, q.sta, q.srw, q.busy, q.full};
         end else if (hit(paddr, `TW_OFF_CMD)) begin
            d.prdata[7:0] = {4'h0, q.mst};
         end else if (hit(paddr, `TW_OFF_OWN)) begin
            d.prdata[7:0] = {1'b0, q.own};
         end else begin
            d.pslverr = 1'b1;
         end
      end else if (acc) begin
         d.pslverr = q.pslverr;
      end

      // Register writes and read side effects take place in the access cycle.
      if (acc && !pwrite && hit(paddr, `TW_OFF_BUF)) begin
         d.full = 1'b0;
      end
      if (acc && pwrite) begin
         if (hit(paddr, `TW_OFF_BUF)) begin
            if (q.mst != M_IDLE && q.mst != M_HOLD) begin
               d.wcol = 1'b1;
            end else begin
               d.buf_q = pwdata[7:0];
               if (q.mst == M_HOLD) begin
                  d.msh  = pwdata[7:0];
                  d.mrx  = 1'b0;
                  d.mbit = 4'h0;
                  d.mst  = M_LOW;
               end
            end
         end else if (hit(paddr, `TW_OFF_CTL1)) begin
            d.wcol   = q.wcol & pwdata[`TW_C1_WCOL];
            d.ovf    = q.ovf & pwdata[`TW_C1_OVF];
            d.en     = pwdata[`TW_C1_EN];
            d.rel    = pwdata[`TW_C1_REL];
            d.mst_en = pwdata[`TW_C1_MST];
         end else if (hit(paddr, `TW_OFF_CTL3)) begin
            d.nack_next = pwdata[`TW_C3_NACK];
         end else if (hit(paddr, `TW_OFF_FLAGS)) begin
            d.arb     = q.arb & ~pwdata[7];
            d.mis     = q.mis & ~pwdata[6];
            d.nack_rx = q.nack_rx & ~pwdata[5];
            d.sto     = q.sto & ~pwdata[4];
            d.sta     = q.sta & ~pwdata[3];
         end else if (hit(paddr, `TW_OFF_OWN)) begin
            d.own = pwdata[6:0];
         end else if (hit(paddr, `TW_OFF_CMD)) begin
            if (pwdata[`TW_CMD_START]) begin
               // A new message starts only on an idle bus, else wcol is set; the buffer holds address and direction.
               if (q.mst == M_IDLE && q.mst_en && q.en && !q.busy && nscl && nsda) begin
                  d.mst  = M_STA1;
                  d.msh  = q.buf_q;
                  d.mrx  = 1'b0;
                  d.qcnt = 10'h000;
               end else begin
                  d.wcol = 1'b1;
               end
            end else if (q.mst == M_HOLD) begin
               d.qcnt = 10'h000;
               if (pwdata[`TW_CMD_RESTART]) begin
                  d.mst = M_RS1;
               end else if (pwdata[`TW_CMD_STOP]) begin
                  d.mst = M_STO1;
               end else if (pwdata[`TW_CMD_RECV]) begin
                  d.mrx  = 1'b1;
                  d.mbit = 4'h0;
                  d.mst  = M_LOW;
               end
            end else begin
               d.wcol = 1'b1;
            end
         end
      end

      // Master bit engine, one quarter period per phase.
      case (q.mst)
         M_IDLE: begin
            d.qcnt = 10'h000;
            d.mscl = 1'b0;
            d.msda = 1'b0;
         end
         M_STA1: begin
            d.msda = 1'b1;
            if (tick) begin
               d.mst  = M_STA2;
               d.mscl = 1'b1;
               d.qcnt = 10'h000;
            end
         end
         M_STA2: begin
            if (tick) begin
               d.mst  = M_LOW;
               d.mbit = 4'h0;
               d.qcnt = 10'h000;
            end
         end
         M_LOW: begin
            d.mscl = 1'b1;
            if (q.qcnt == QHALF) begin
               // Data moves only in the middle of the low phase.
               if (q.mbit == 4'h8) begin
                  d.msda = q.mrx & ~q.nack_next;
               end else begin
                  d.msda = ~q.mrx & ~q.msh[7];
               end
            end
            if (tick) begin
               d.mst  = M_HIGH;
               d.mscl = 1'b0;
               d.qcnt = 10'h000;
            end
         end
         M_HIGH: begin
            if (!nscl) begin
               d.qcnt = 10'h000;
            end else begin
               if (scl_rise) begin
                  if (q.mbit != 4'h8) begin
                     d.msh = {q.msh[6:0], nsda};
                     if (!q.mrx && !q.msda && !nsda) begin
                        d.arb  = 1'b1;
                        d.msda = 1'b0;
                        d.mscl = 1'b0;
                        d.mst  = M_IDLE;
                     end
                  end else if (!q.mrx) begin
                     d.nack_rx = nsda;
                  end
               end
               if (tick) begin
                  d.mscl = 1'b1;
                  d.qcnt = 10'h000;
                  if (q.mbit == 4'h8) begin
                     d.mst = M_HOLD;
                     if (q.mrx) begin
                        d.buf_q = q.msh;
                        d.full  = 1'b1;
                        d.ovf   = q.ovf | q.full;
                     end
                  end else begin
                     d.mbit = q.mbit + 4'h1;
                     d.mst  = M_LOW;
                  end
               end
            end
         end
         M_HOLD: begin
            d.mscl = 1'b1;
         end
         M_STO1: begin
            d.mscl = 1'b1;
            d.msda = 1'b1;
            if (tick) begin
               d.mst  = M_STO2;
               d.mscl = 1'b0;
               d.qcnt = 10'h000;
            end
         end
         M_STO2: begin
            if (!nscl) begin
               d.qcnt = 10'h000;
            end else if (tick) begin
               d.mst  = M_STO3;
               d.msda = 1'b0;
               d.qcnt = 10'h000;
            end
         end
         M_STO3: begin
            if (tick) begin
               d.mst = M_IDLE;
            end
         end
         M_RS1: begin
            d.mscl = 1'b1;
            d.msda = 1'b0;
            if (tick) begin
               d.mst  = M_RS2;
               d.mscl = 1'b0;
               d.qcnt = 10'h000;
            end
         end
         M_RS2: begin
            if (!nscl) begin
               d.qcnt = 10'h000;
            end else if (tick) begin
               d.mst  = M_STA1;
               d.qcnt = 10'h000;
            end
         end
         default: begin
            d.mst = M_IDLE;
         end
      endcase

      // Slave engine driven by the sampled bus edges.
      if (scl_rise && q.slv != S_IDLE && q.slv != S_WAIT) begin
         if (q.sbit != 4'h8) begin
            d.ssh = {q.ssh[6:0], nsda};
            if (q.slv == S_TX && !q.ssda && !nsda) begin
               d.mis = 1'b1;
            end
         end else if (q.slv == S_TX) begin
            d.nack_rx = nsda;
            if (nsda) begin
               d.slv = S_WAIT;
            end
         end
      end
      if (scl_fall && q.slv != S_IDLE && q.slv != S_WAIT) begin
         // The clock fall that closes a Start condition carries no bit.
         if (q.sbit == 4'hF) begin
            d.sbit = 4'h0;
         end else if (q.sbit == 4'h7) begin
            d.sbit = 4'h8;
            d.ssda = 1'b0;
            if (q.slv == S_ADDR) begin
               if (q.ssh[7:1] == q.own) begin
                  d.ssda = 1'b1;
                  d.srw  = q.ssh[0];
               end else begin
                  d.slv = S_WAIT;
               end
            end else if (q.slv == S_RX) begin
               if (q.full) begin
                  d.ovf = 1'b1;
               end else begin
                  d.buf_q = q.ssh;
                  d.full  = 1'b1;
                  d.ssda  = 1'b1;
               end
            end
         end else if (q.sbit == 4'h8) begin
            d.sbit = 4'h0;
            d.ssda = 1'b0;
            if ((q.slv == S_ADDR && q.srw) || q.slv == S_TX) begin
               d.slv  = S_TX;
               d.sscl = 1'b1;
               d.rel  = 1'b0;
            end else begin
               d.slv = S_RX;
            end
         end else begin
            d.sbit = q.sbit + 4'h1;
            if (q.slv == S_TX) begin
               d.ssda = ~q.ssh[7];
            end
         end
      end
      if (q.sscl && q.rel) begin
         d.ssh  = q.buf_q;
         d.full = 1'b0;
         d.ssda = ~q.buf_q[7];
         d.sscl = 1'b0;
      end
      if (start_det) begin
         d.sta  = 1'b1;
         d.busy = 1'b1;
         d.sbit = 4'hF;
         d.ssda = 1'b0;
         d.sscl = 1'b0;
         d.slv  = q.en ? S_ADDR : S_IDLE;
      end
      if (stop_det) begin
         d.sto  = 1'b1;
         d.busy = 1'b0;
         d.ssda = 1'b0;
         d.sscl = 1'b0;
         d.slv  = S_IDLE;
      end
      if (!q.en) begin
         d.mst  = M_IDLE;
         d.slv  = S_IDLE;
         d.mscl = 1'b0;
         d.msda = 1'b0;
         d.ssda = 1'b0;
         d.sscl = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q        <= '0;
         q.scl_sy <= 3'h7;
         q.sda_sy <= 3'h7;
         q.scl_f  <= 1'b1;
         q.sda_f  <= 1'b1;
         q.mst    <= M_IDLE;
         q.slv    <= S_IDLE;
         q.own    <= `TW_OWN_RESET;
         hold_q   <= 1'b0;
         oe_scl_q <= 1'b0;
         oe_sda_q <= 1'b0;
      end else begin
         q        <= d;
         hold_q   <= d.sscl & ~d.rel;
         oe_scl_q <= d.mscl | d.sscl;
         oe_sda_q <= d.msda | d.ssda;
      end
   end

   assign prdata  = q.prdata;
   assign pready  = q.pready;
   assign pslverr = q.pslverr;
   assign scl_o   = 1'b0;
   assign sda_o   = 1'b0;
   assign scl_oe  = oe_scl_q;
   assign sda_oe  = oe_sda_q;

   AST_SYNC_AGREE: assert property (@(posedge pclk) disable iff (!presetn)
      (q.scl_f != $past(q.scl_f)) |-> $past(q.scl_sy[1]) == $past(q.scl_sy[2]))
      else $error("clock level changed without two agreeing stages");
   AST_START_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
      start_det |=> q.sta && q.busy)
      else $error("start condition not flagged");
   AST_STOP_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
      stop_det |=> q.sto && !q.busy)
      else $error("stop condition not flagged");
   AST_HIGH_STABLE: assert property (@(posedge pclk) disable iff (!presetn)
      (q.mst == M_HIGH && $past(q.mst) == M_HIGH) |-> $stable(q.msda))
      else $error("master data moved while clock high");
   AST_CLOCK_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
      (q.mst == M_HIGH && !nscl && q.en) |=> q.mst == M_HIGH && q.qcnt == 10'h000)
      else $error("master went on while clock held low");
   AST_ARB_RELEASE: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(q.arb) |-> !q.msda && !q.mscl ##1 !sda_oe || q.ssda)
      else $error("losing master still drives");
   AST_SLAVE_ACK: assert property (@(posedge pclk) disable iff (!presetn)
      (scl_fall && q.slv == S_ADDR && q.sbit == 4'h7 && q.ssh[7:1] == q.own && q.en
       && !start_det && !stop_det) |=> q.ssda ##1 sda_oe)
      else $error("own address not acknowledged");
   AST_STRETCH: assert property (@(posedge pclk) disable iff (!presetn)
      (hold_q && !start_det && !stop_det && q.en && !(acc && pwrite)) |=> scl_oe)
      else $error("clock not held by unready slave");
   AST_NINE_SLOTS: assert property (@(posedge pclk) disable iff (!presetn)
      (q.mst == M_HIGH && q.mbit == 4'h8 && tick && nscl) |=> q.mst == M_HOLD)
      else $error("byte did not end after nine slots");

   COV_MASTER_START: cover property (@(posedge pclk) disable iff (!presetn)
      q.mst == M_STA1 ##1 q.mst == M_STA1);
   COV_SLAVE_TX: cover property (@(posedge pclk) disable iff (!presetn)
      q.slv == S_ADDR ##1 q.slv == S_TX);
   COV_ARB_LOST: cover property (@(posedge pclk) disable iff (!presetn) $rose(q.arb));
   COV_RESTART: cover property (@(posedge pclk) disable iff (!presetn)
      q.mst == M_RS2 ##1 q.mst == M_STA1);

endmodule

// [verif/two_wire_peer.sv]
// Purpose: Bus peer that acts as a master or as an acknowledging slave.
// Assumes: A bit period of 33 pclk cycles, which is 165 ns.
// Notes:   An output that is high pulls its line low.
`timescale 1ns/10ps
module two_wire_peer (
   input  wire logic pclk,
   input  wire logic scl,
   input  wire logic sda,
   output logic      scl_low,
   output logic      sda_low
);
   int         tmo;
   int         cnt;
   int         hold;
   logic       resp_en;
   logic       scl_p;
   logic       sda_p;
   logic [7:0] sh;
   logic [7:0] got [$];
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
      resp_en = 1'b0;
      tmo = 0;
      cnt = 0;
      hold = 0;
   end
   task automatic hp(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic bit_io(input logic b, output logic s);
      int i;
      hp(8);
      sda_low <= !b;
      hp(8);
      scl_low <= 1'b0;
      i = 0;
      while (scl !== 1'b1 && i < 4000) begin
         hp(1);
         i++;
      end
      if (i == 4000) tmo++;
      s = sda;
      hp(16);
      scl_low <= 1'b1;
   endtask
   task automatic start();
      sda_low <= 1'b1;
      hp(16);
      scl_low <= 1'b1;
   endtask
   task automatic stop();
      hp(8);
      sda_low <= 1'b1;
      hp(8);
      scl_low <= 1'b0;
      hp(16);
      sda_low <= 1'b0;
      hp(32);
   endtask
   task automatic byte_out(input logic [7:0] d, output logic ack);
      for (int k = 7; k >= 0; k--) bit_io(d[k], ack);
      bit_io(1'b1, ack);
   endtask
   task automatic byte_in(input logic nack, output logic [7:0] d);
      logic s;
      for (int k = 7; k >= 0; k--) bit_io(1'b1, d[k]);
      bit_io(nack, s);
   endtask
   // Slave responder: acknowledges every byte and stretches after each.
   always @(posedge pclk) begin
      scl_p <= scl;
      sda_p <= sda;
      if (resp_en) begin
         if (scl && scl_p && sda_p && !sda) cnt <= 0;
         if (scl && !scl_p && cnt < 8) sh <= {sh[6:0], sda};
         if (scl && !scl_p) cnt <= cnt + 1;
         if (!scl && scl_p && cnt == 8) sda_low <= 1'b1;
         if (!scl && scl_p && cnt == 9) begin
            sda_low <= 1'b0;
            scl_low <= 1'b1;
            hold <= 600;
            got.push_back(sh);
            cnt <= 0;
         end
         if (hold == 1) scl_low <= 1'b0;
         if (hold != 0) hold <= hold - 1;
      end
   end
endmodule

// [verif/two_wire_bus_signalling_tb.sv]
// Purpose: Self-checking bench of the two-wire unit against a bus peer.
// Assumes: Pull-ups on both lines; the peer runs its bit clock at 165 ns.
// Notes:   Random bytes come from a fixed seed.
`timescale 1ns/10ps
`include "two_wire_cfg.svh"
module two_wire_bus_signalling_tb
   import two_wire_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   logic        pready, pslverr, scl_oe, sda_oe, p_scl, p_sda, ack, err;
   wire         scl = !(scl_oe || p_scl);
   wire         sda = !(sda_oe || p_sda);
   int          errors, checks;
   integer      seed;
   logic [6:0]  own, pa;
   logic [7:0]  dat, tx, rx;
   two_wire_bus_signalling u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .scl_i(scl), .scl_o(),
      .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe)
   );
   two_wire_peer u_peer (
      .pclk(pclk), .scl(scl), .sda(sda), .scl_low(p_scl), .sda_low(p_sda)
   );
   always #2.5 pclk = ~pclk;
   task automatic summarize();
      errors += u_peer.tmo;
      if (errors == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n == 50) begin
         errors++;
         summarize();
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, r);
   endtask
   task automatic wait_mst(input mst_t s, input logic eq);
      int n;
      n = 0;
      do begin
         apb(1'b0, `TW_OFF_CMD, 32'h0, r);
         n++;
      end while (((r[3:0] === s) != eq) && n < 10000);
      if (n == 10000) begin
         errors++;
         summarize();
      end
   endtask
   initial begin
      repeat (100000) @(posedge pclk);
      errors++;
      summarize();
   end
   initial begin
      seed = 32'hE406;
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      errors = 0;
      checks = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      apb(1'b0, `TW_OFF_OWN, 32'h0, r);
      chk(r, {25'h0, `TW_OWN_RESET});
      apb(1'b0, `TW_OFF_CTL1, 32'h0, r);
      chk(r, 32'h0);
      apb(1'b0, 8'h18, 32'h0, r);
      chk({r[30:0], err}, 32'h1);
      own = 7'($random(seed)) | 7'h08;
      dat = 8'($random(seed));
      tx = 8'($random(seed));
      pa = own ^ 7'h10;
      wr(`TW_OFF_OWN, {25'h0, own});
      wr(`TW_OFF_CTL1, 32'h20);
      wr(`TW_OFF_FLAGS, 32'hF8);
      // Slave receive: address and one data byte, both acknowledged.
      u_peer.start();
      u_peer.byte_out({own, 1'b0}, ack);
      chk({31'h0, ack}, 32'h0);
      u_peer.byte_out(dat, ack);
      chk({31'h0, ack}, 32'h0);
      u_peer.stop();
      apb(1'b0, `TW_OFF_FLAGS, 32'h0, r);
      chk(r & 32'h1F, 32'h19);
      apb(1'b0, `TW_OFF_BUF, 32'h0, r);
      chk(r, {24'h0, dat});
      // A foreign address is left unacknowledged.
      u_peer.start();
      u_peer.byte_out({own ^ 7'h01, 1'b0}, ack);
      chk({31'h0, ack}, 32'h1);
      u_peer.stop();
      // Slave transmit: clock is stretched until software releases it.
      u_peer.start();
      u_peer.byte_out({own, 1'b1}, ack);
      chk({31'h0, ack}, 32'h0);
      fork
         u_peer.byte_in(1'b1, rx);
         begin
            repeat (200) @(posedge pclk);
            chk({31'h0, scl}, 32'h0);
            apb(1'b0, `TW_OFF_FLAGS, 32'h0, r);
            chk(r & 32'h4, 32'h4);
            wr(`TW_OFF_BUF, {24'h0, tx});
            wr(`TW_OFF_CTL1, 32'h30);
         end
      join
      chk({24'h0, rx}, {24'h0, tx});
      u_peer.stop();
      // Master write of address and one byte to a stretching peer.
      u_peer.resp_en <= 1'b1;
      wr(`TW_OFF_FLAGS, 32'hF8);
      wr(`TW_OFF_BUF, {24'h0, pa, 1'b0});
      wr(`TW_OFF_CTL1, 32'h28);
      wr(`TW_OFF_CMD, 32'h1);
      wait_mst(M_HOLD, 1'b1);
      apb(1'b0, `TW_OFF_FLAGS, 32'h0, r);
      chk(r & 32'h20, 32'h0);
      wr(`TW_OFF_BUF, {24'h0, dat});
      wait_mst(M_HOLD, 1'b0);
      wait_mst(M_HOLD, 1'b1);
      wr(`TW_OFF_CMD, 32'h4);
      wait_mst(M_IDLE, 1'b1);
      apb(1'b0, `TW_OFF_FLAGS, 32'h0, r);
      chk(r & 32'h30, 32'h10);
      chk(u_peer.got.size(), 2);
      chk({24'h0, u_peer.got[0]}, {24'h0, pa, 1'b0});
      chk({24'h0, u_peer.got[1]}, {24'h0, dat});
      summarize();
   end
endmodule
